// ==== verilog/reserved_mcast_igmp_ctrl.sv ====
// reserved multicast frame decisions and hardware igmp router port aging
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`include "reserved_mcast_igmp_params.svh"

module reserved_mcast_igmp_ctrl #(
  parameter int unsigned TICK_CYCLES = `ONE_SEC_NS / `CLK_PERIOD_NS
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic [9:0]                          address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [31:0]                         writedata,
  output logic      [31:0]                         readdata,
  output logic                                     waitrequest,
  input  wire logic                                frmValid,
  input  reserved_mcast_igmp_pkg::frame_class_t    frmClass,
  input  wire logic                                frmOpcode01,
  input  wire logic                                frmFromCpu,
  output logic                                     decValid,
  output reserved_mcast_igmp_pkg::fwd_action_t     decAction,
  output logic                                     decMgmt,
  output logic                                     decSpan,
  output logic                                     decCrossVlan,
  output reserved_mcast_igmp_pkg::tx_tag_t         decTxTag,
  input  wire logic                                queryValid,
  input  wire logic [2:0]                          queryPort,
  output logic      [`NUM_PORTS-1:0]               routerPorts
);
  import reserved_mcast_igmp_pkg::*;

  // every check below runs on the core clock and sleeps through reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [15:0]            rsvCtrl_q;
  logic [15:0]            igmpCtrl_q;
  logic [1:0]             snoopEn_q;
  logic                   ack_q;
  logic [31:0]            readdata_q;
  logic [31:0]            rdMux;
  logic                   wrTake;
  logic                   decValid_q;
  fwd_action_t            decAction_q;
  fwd_action_t            actD;
  logic                   decMgmt_q;
  logic                   decSpan_q;
  logic                   decCross_q;
  tx_tag_t                decTxTag_q;
  tx_tag_t                tagD;
  logic [31:0]            tickCnt_q;
  logic                   tick_q;
  logic [`NUM_PORTS-1:0]  learned_q;
  logic [`NUM_PORTS-1:0]  routerPorts_q;
  logic [`NUM_PORTS-1:0]  effRouter;
  logic [`AGE_W-1:0]      ageReload;
  logic [1:0]             otherAct;
  logic [1:0]             robustEff;
  logic                   hwSnoop;
  logic                   defRouter;

  assign otherAct  = rsvCtrl_q[`F_OTHER_ACT_HI:`F_OTHER_ACT_LO];
  assign hwSnoop   = snoopEn_q[`F_HW_SNOOP_EN];
  assign defRouter = snoopEn_q[`F_DEF_ROUTER_EN];

  // ****************************************************************
  // avalon slave: one wait cycle, then the answer
  // ****************************************************************
  assign waitrequest = (read | write) & ~ack_q;
  assign wrTake      = write & ack_q;
  assign readdata    = readdata_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // unmapped addresses read zero and drop writes
  always_comb begin
    rdMux = 32'h0000_0000;
    if (address == `REG_ADDR(`IDX_RSV_CTRL_B)) begin
      rdMux[15:0] = rsvCtrl_q;
    end else if (address == `REG_ADDR(`IDX_IGMP_CTRL)) begin
      rdMux[15:0] = igmpCtrl_q;
    end else if (address == `REG_ADDR(`IDX_SNOOP_EN)) begin
      rdMux[1:0] = snoopEn_q;
    end else if (address == `REG_ADDR(`IDX_SNOOP_STATUS)) begin
      rdMux[`NUM_PORTS-1:0] = learned_q;
      rdMux[`F_STAT_EFF_LO +: `NUM_PORTS] = routerPorts_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (read & ~ack_q) begin
      readdata_q <= rdMux;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsvCtrl_q  <= `RSV_CTRL_B_RESET;
      igmpCtrl_q <= `IGMP_CTRL_RESET;
      snoopEn_q  <= `SNOOP_EN_RESET;
    end else if (wrTake) begin
      if (address == `REG_ADDR(`IDX_RSV_CTRL_B)) begin
        rsvCtrl_q <= writedata[15:0];
      end else if (address == `REG_ADDR(`IDX_IGMP_CTRL)) begin
        igmpCtrl_q <= writedata[15:0];
      end else if (address == `REG_ADDR(`IDX_SNOOP_EN)) begin
        snoopEn_q <= writedata[1:0];
      end
    end
  end

  // ****************************************************************
  // reserved group frame decision, one cycle after the frame strobe
  // ****************************************************************
  always_comb begin
    actD = ACT_DEFAULT;
    tagD = TAG_SYS_DEFAULT;
    if (frmClass == CLS_MACCTL) begin
      if (frmOpcode01 && rsvCtrl_q[`F_OP01_DISCARD]) begin
        actD = ACT_DISCARD;
      end else begin
        case (otherAct)
          `OTHER_ACT_DEFAULT: actD = ACT_DEFAULT;
          `OTHER_ACT_DISCARD: actD = ACT_DISCARD;
          `OTHER_ACT_CPU_SEL: actD = frmFromCpu ? ACT_DEFAULT : ACT_TO_CPU;
          default:            actD = ACT_NO_CPU;
        endcase
      end
    end
    if (frmClass == CLS_GXRP) begin
      tagD = tx_tag_t'(rsvCtrl_q[`F_GXRP_TAG_HI:`F_GXRP_TAG_LO]);
    end else if (frmClass == CLS_SLOWGRP) begin
      // code 00 lands on system default through the enum order
      tagD = tx_tag_t'(rsvCtrl_q[`F_SLOW_TAG_HI:`F_SLOW_TAG_LO]);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      decValid_q  <= 1'b0;
      decAction_q <= ACT_DEFAULT;
      decMgmt_q   <= 1'b0;
      decSpan_q   <= 1'b0;
      decCross_q  <= 1'b0;
      decTxTag_q  <= TAG_SYS_DEFAULT;
    end else begin
      decValid_q  <= frmValid;
      decAction_q <= actD;
      decTxTag_q  <= tagD;
      decMgmt_q   <= ((frmClass == CLS_GXRP) && rsvCtrl_q[`F_GXRP_MGMT])
                   | ((frmClass == CLS_SLOWGRP) && rsvCtrl_q[`F_SLOW_MGMT])
                   | ((frmClass == CLS_BPDU) && rsvCtrl_q[`F_BPDU_MGMT]);
      decSpan_q   <= ((frmClass == CLS_GXRP) && rsvCtrl_q[`F_GXRP_SPAN])
                   | ((frmClass == CLS_SLOWGRP) && rsvCtrl_q[`F_SLOW_SPAN])
                   | ((frmClass == CLS_BPDU) && rsvCtrl_q[`F_BPDU_SPAN]);
      decCross_q  <= ((frmClass == CLS_GXRP) && rsvCtrl_q[`F_GXRP_CROSS])
                   | ((frmClass == CLS_SLOWGRP) && rsvCtrl_q[`F_SLOW_CROSS])
                   | ((frmClass == CLS_BPDU) && rsvCtrl_q[`F_BPDU_CROSS]);
    end
  end

  assign decValid     = decValid_q;
  assign decAction    = decAction_q;
  assign decMgmt      = decMgmt_q;
  assign decSpan      = decSpan_q;
  assign decCrossVlan = decCross_q;
  assign decTxTag     = decTxTag_q;

  // ****************************************************************
  // one second tick from the core clock
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickCnt_q <= 32'h0000_0000;
      tick_q    <= 1'b0;
    end else begin
      tick_q    <= (tickCnt_q == 32'(TICK_CYCLES - 1));
      tickCnt_q <= (tickCnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // router port learning and aging
  // ****************************************************************
  // reserved robustness is run as one time so a bad setting cannot stall aging
  assign robustEff = (igmpCtrl_q[`F_ROBUST_HI:`F_ROBUST_LO] == `ROBUST_RESERVED) ? `ROBUST_ONE
                   : igmpCtrl_q[`F_ROBUST_HI:`F_ROBUST_LO];
  // both factors widened first so the product cannot wrap at eight bits
  assign ageReload = `AGE_W'(igmpCtrl_q[`F_QINT_HI:`F_QINT_LO]) * `AGE_W'(robustEff);

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    logic [`AGE_W-1:0] timer_q;
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        timer_q      <= '0;
        learned_q[p] <= 1'b0;
      end else if (!hwSnoop) begin
        timer_q      <= '0;
        learned_q[p] <= 1'b0;
      end else if (queryValid && (queryPort == 3'(p))) begin
        timer_q      <= ageReload;
        learned_q[p] <= 1'b1;
      end else if (tick_q && learned_q[p]) begin
        if (timer_q <= `AGE_W'(1)) begin
          timer_q      <= '0;
          learned_q[p] <= 1'b0;
        end else begin
          timer_q <= timer_q - `AGE_W'(1);
        end
      end
    end

    AST_AGE_OUT: assert property (
      (learned_q[p] && tick_q && timer_q <= `AGE_W'(1) && hwSnoop && !(queryValid && queryPort == 3'(p)))
      |=> !learned_q[p] && timer_q == '0)
      else $error("router port did not age out when its timer expired");

    AST_QUERY_RELOAD: assert property (
      (hwSnoop && queryValid && queryPort == 3'(p))
      |=> learned_q[p] && timer_q == $past(ageReload))
      else $error("query did not reload the router port timer");
  end

  assign effRouter = hwSnoop ? (learned_q | (defRouter ? igmpCtrl_q[`F_RTR_MAP_HI:`F_RTR_MAP_LO] : '0))
                   : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      routerPorts_q <= '0;
    end else begin
      routerPorts_q <= effRouter;
    end
  end

  assign routerPorts = routerPorts_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_ctl_frame;
    frmValid && frmClass == CLS_MACCTL;
  endsequence

  sequence s_ctl_other;
    s_ctl_frame ##0 !(frmOpcode01 && rsvCtrl_q[`F_OP01_DISCARD]);
  endsequence

  AST_OP01_DISCARD: assert property (
    s_ctl_frame ##0 (frmOpcode01 && rsvCtrl_q[`F_OP01_DISCARD]) |=> decValid && decAction == ACT_DISCARD)
    else $error("opcode 01 frame not discarded");

  AST_OTHER_ACTION: assert property (
    s_ctl_other ##0 (otherAct != `OTHER_ACT_CPU_SEL)
    |=> decValid && decAction == (($past(otherAct) == `OTHER_ACT_DEFAULT) ? ACT_DEFAULT
        : ($past(otherAct) == `OTHER_ACT_DISCARD) ? ACT_DISCARD : ACT_NO_CPU))
    else $error("mac control action does not follow its code");

  AST_CPU_SELECT: assert property (
    s_ctl_other ##0 (otherAct == `OTHER_ACT_CPU_SEL)
    |=> decAction == ($past(frmFromCpu) ? ACT_DEFAULT : ACT_TO_CPU))
    else $error("cpu select action wrong for receiving port");

  AST_MGMT_MARK: assert property (
    frmValid && frmClass == CLS_BPDU |=> decMgmt == $past(rsvCtrl_q[`F_BPDU_MGMT]))
    else $error("bpdu management mark does not follow its bit");

  AST_SPAN_MARK: assert property (
    frmValid && frmClass == CLS_GXRP |=> decSpan == $past(rsvCtrl_q[`F_GXRP_SPAN]))
    else $error("gxrp span mark does not follow its bit");

  AST_CROSS_VLAN: assert property (
    frmValid && frmClass == CLS_SLOWGRP |=> decCrossVlan == $past(rsvCtrl_q[`F_SLOW_CROSS]))
    else $error("slow group cross vlan does not follow its bit");

  AST_GXRP_TAG: assert property (
    frmValid && frmClass == CLS_GXRP
    |=> 2'(decTxTag) == $past(rsvCtrl_q[`F_GXRP_TAG_HI:`F_GXRP_TAG_LO]))
    else $error("gxrp tag selection wrong");

  AST_SLOW_TAG: assert property (
    frmValid && frmClass == CLS_SLOWGRP && rsvCtrl_q[`F_SLOW_TAG_HI:`F_SLOW_TAG_LO] != 2'h0
    |=> 2'(decTxTag) == $past(rsvCtrl_q[`F_SLOW_TAG_HI:`F_SLOW_TAG_LO]))
    else $error("slow group tag selection wrong");

  AST_SLOW_TAG_DEFAULT: assert property (
    frmValid && frmClass == CLS_SLOWGRP && rsvCtrl_q[`F_SLOW_TAG_HI:`F_SLOW_TAG_LO] == 2'h0
    |=> decTxTag == TAG_SYS_DEFAULT)
    else $error("slow group code 00 not system default");

  AST_ROBUST_RELOAD: assert property (
    igmpCtrl_q[`F_ROBUST_HI:`F_ROBUST_LO] == 2'h3
    |-> ageReload == `AGE_W'(igmpCtrl_q[`F_QINT_HI:`F_QINT_LO]) * `AGE_W'(3))
    else $error("robustness three not applied");

  AST_STATIC_ROUTER: assert property (
    hwSnoop && defRouter ##1 hwSnoop && defRouter && $stable(igmpCtrl_q)
    |-> (routerPorts & igmpCtrl_q[`F_RTR_MAP_HI:`F_RTR_MAP_LO]) == igmpCtrl_q[`F_RTR_MAP_HI:`F_RTR_MAP_LO])
    else $error("static router ports missing from router map");

  AST_SNOOP_OFF: assert property (
    !hwSnoop [*2] |-> routerPorts == '0 && learned_q == '0)
    else $error("router ports active while snooping disabled");

  AST_BUS_ANSWER: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one wait cycle");

endmodule // reserved_mcast_igmp_ctrl

// ==== common/reserved_mcast_igmp_params.svh ====
// constants for the reserved multicast and igmp snooping control block
`ifndef RESERVED_MCAST_IGMP_PARAMS_SVH
`define RESERVED_MCAST_IGMP_PARAMS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define IDX_SNOOP_EN      8'h0C
`define IDX_RSV_CTRL_B    8'h3E
`define IDX_IGMP_CTRL     8'h3F
`define IDX_SNOOP_STATUS  8'h70
`define REG_ADDR(idx)     {idx, 2'b00}

// ****************************************************************
// reset values
// ****************************************************************
`define RSV_CTRL_B_RESET  16'h0000
`define IGMP_CTRL_RESET   16'h7C80
`define SNOOP_EN_RESET    2'h0

// ****************************************************************
// reserved address control b fields
// ****************************************************************
`define F_OP01_DISCARD    15
`define F_OTHER_ACT_HI    14
`define F_OTHER_ACT_LO    13
`define F_GXRP_MGMT       12
`define F_SLOW_MGMT       11
`define F_BPDU_MGMT       10
`define F_GXRP_SPAN       9
`define F_SLOW_SPAN       8
`define F_BPDU_SPAN       7
`define F_GXRP_CROSS      6
`define F_SLOW_CROSS      5
`define F_BPDU_CROSS      4
`define F_GXRP_TAG_HI     3
`define F_GXRP_TAG_LO     2
`define F_SLOW_TAG_HI     1
`define F_SLOW_TAG_LO     0

// ****************************************************************
// igmp control, snoop enable and snoop status fields
// ****************************************************************
`define F_QINT_HI         15
`define F_QINT_LO         8
`define F_ROBUST_HI       7
`define F_ROBUST_LO       6
`define F_RTR_MAP_HI      5
`define F_RTR_MAP_LO      0
`define F_HW_SNOOP_EN     0
`define F_DEF_ROUTER_EN   1
`define F_STAT_EFF_LO     8

// ****************************************************************
// codes, sizes and timing
// ****************************************************************
`define OTHER_ACT_DEFAULT 2'h0
`define OTHER_ACT_DISCARD 2'h1
`define OTHER_ACT_CPU_SEL 2'h2
`define ROBUST_RESERVED   2'h0
`define ROBUST_ONE        2'h1
`define NUM_PORTS         6
`define AGE_W             10
`define ONE_SEC_NS        1000000000
`define CLK_PERIOD_NS     10

`endif

// ==== common/reserved_mcast_igmp_pkg.sv ====
// types for the reserved multicast and igmp snooping control block
package reserved_mcast_igmp_pkg;
  typedef enum logic [2:0] {CLS_NONE, CLS_MACCTL, CLS_GXRP, CLS_SLOWGRP, CLS_BPDU} frame_class_t;
  typedef enum logic [1:0] {ACT_DEFAULT, ACT_DISCARD, ACT_TO_CPU, ACT_NO_CPU} fwd_action_t;
  typedef enum logic [1:0] {TAG_SYS_DEFAULT, TAG_UNMODIFIED, TAG_ALWAYS, TAG_NEVER} tx_tag_t;
endpackage

// ==== dv/test_reserved_mcast_igmp_ctrl.sv ====
// self-checking testbench for the reserved multicast and igmp snooping control block
`timescale 1ns/1ns
`include "reserved_mcast_igmp_params.svh"

module test_reserved_mcast_igmp_ctrl;
  import reserved_mcast_igmp_pkg::*;
  // ****************************************************************
  // setup
  // ****************************************************************
  // short tick keeps the aging runs to a few hundred cycles
  localparam int        TICK    = 20;
  localparam int        QINT    = 3;
  localparam logic [9:0] ADR_RSV = `REG_ADDR(`IDX_RSV_CTRL_B);
  localparam logic [9:0] ADR_IGM = `REG_ADDR(`IDX_IGMP_CTRL);
  localparam logic [9:0] ADR_EN  = `REG_ADDR(`IDX_SNOOP_EN);
  localparam logic [9:0] ADR_ST  = `REG_ADDR(`IDX_SNOOP_STATUS);
  logic                  ref_clk;
  logic                  rst;
  logic [9:0]            address;
  logic                  read;
  logic                  write;
  logic [31:0]           writedata;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  frmValid;
  frame_class_t          frmClass;
  logic                  frmOpcode01;
  logic                  frmFromCpu;
  logic                  decValid;
  fwd_action_t           decAction;
  logic                  decMgmt;
  logic                  decSpan;
  logic                  decCrossVlan;
  tx_tag_t               decTxTag;
  logic                  queryValid;
  logic [2:0]            queryPort;
  logic [`NUM_PORTS-1:0] routerPorts;
  int                    failures;
  int                    testsRun;

  reserved_mcast_igmp_ctrl #(.TICK_CYCLES(TICK)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .frmValid(frmValid), .frmClass(frmClass), .frmOpcode01(frmOpcode01), .frmFromCpu(frmFromCpu),
    .decValid(decValid), .decAction(decAction), .decMgmt(decMgmt), .decSpan(decSpan),
    .decCrossVlan(decCrossVlan), .decTxTag(decTxTag), .queryValid(queryValid),
    .queryPort(queryPort), .routerPorts(routerPorts)
  );

  always #5 ref_clk = ~ref_clk;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // values read right after a rising edge are the ones the slave showed at that edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int   n;
    logic w;
    n  = 0;
    w  = 1'b1;
    rd = 32'h0000_0000;
    @(posedge ref_clk);
    address   <= a;
    writedata <= wd;
    read      <= ~wr;
    write     <= wr;
    while (w !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      w  = waitrequest;
      rd = readdata;
      n++;
    end
    read  <= 1'b0;
    write <= 1'b0;
    if (w !== 1'b0) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    check(nm, rd, e);
  endtask

  task automatic frame(input frame_class_t c, input logic op, input logic cpu, input fwd_action_t ea,
                       input logic [2:0] ems, input tx_tag_t et);
    @(posedge ref_clk);
    frmValid    <= 1'b1;
    frmClass    <= c;
    frmOpcode01 <= op;
    frmFromCpu  <= cpu;
    @(posedge ref_clk);
    frmValid <= 1'b0;
    @(negedge ref_clk);
    check("decValid", 32'(decValid), 32'h0000_0001);
    check("decAction", 32'(decAction), 32'(ea));
    check("decMgmt", 32'(decMgmt), 32'(ems[2]));
    check("decSpan", 32'(decSpan), 32'(ems[1]));
    check("decCrossVlan", 32'(decCrossVlan), 32'(ems[0]));
    check("decTxTag", 32'(decTxTag), 32'(et));
  endtask

  task automatic query(input logic [2:0] p);
    @(posedge ref_clk);
    queryValid <= 1'b1;
    queryPort  <= p;
    @(posedge ref_clk);
    queryValid <= 1'b0;
  endtask

  // a partial first tick lets the port go up to one tick early
  task automatic age(input int n);
    int c;
    c = 0;
    query(3'h2);
    repeat (2) @(negedge ref_clk);
    while (routerPorts[2] !== 1'b0 && c < n * TICK + 100) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= n * TICK + 100) begin
      failures++;
      finish_test();
    end else begin
      check("ageMin", 32'(c >= (n - 1) * TICK), 32'h0000_0001);
      check("ageMax", 32'(c <= n * TICK + 4), 32'h0000_0001);
    end
  endtask

  task automatic portsChk(input string nm, input logic [5:0] e);
    repeat (3) @(negedge ref_clk);
    check(nm, 32'(routerPorts), 32'(e));
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0]  v;
    frame_class_t cls;
    fwd_action_t  ea;
    ref_clk = 1'b0; rst = 1'b1; address = '0; read = 1'b0; write = 1'b0; writedata = '0;
    frmValid = 1'b0; frmClass = CLS_NONE; frmOpcode01 = 1'b0; frmFromCpu = 1'b0;
    queryValid = 1'b0; queryPort = '0; failures = 0; testsRun = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("rsvReset", ADR_RSV, 32'h0000_0000);
    rdchk("igmpReset", ADR_IGM, 32'h0000_7C80);
    rdchk("enReset", ADR_EN, 32'h0000_0000);
    wr(10'h3FC, 32'h0000_FFFF);
    rdchk("unmapped", 10'h3FC, 32'h0000_0000);
    wr(ADR_RSV, 32'h0000_A5C3);
    rdchk("rsvRw", ADR_RSV, 32'h0000_A5C3);
    // every action code, both discard settings, both opcodes, both ingress kinds
    for (int s = 0; s < 2; s++)
      for (int code = 0; code < 4; code++) begin
        v = '0;
        v[15] = s[0];
        v[14:13] = code[1:0];
        wr(ADR_RSV, v);
        for (int op = 0; op < 2; op++)
          for (int cpu = 0; cpu < 2; cpu++) begin
            ea = (code == 0) ? ACT_DEFAULT : (code == 1) ? ACT_DISCARD :
                 (code == 2) ? (cpu == 1 ? ACT_DEFAULT : ACT_TO_CPU) : ACT_NO_CPU;
            if (s == 1 && op == 1) ea = ACT_DISCARD;
            frame(CLS_MACCTL, op[0], cpu[0], ea, 3'h0, TAG_SYS_DEFAULT);
          end
      end
    // one class bit at a time, seen only by its own class
    for (int b = 4; b < 13; b++) begin
      wr(ADR_RSV, 32'h0000_0001 << b);
      frame(CLS_NONE, 1'b0, 1'b0, ACT_DEFAULT, 3'h0, TAG_SYS_DEFAULT);
      for (int j = 0; j < 3; j++) begin
        cls = (j == 0) ? CLS_GXRP : (j == 1) ? CLS_SLOWGRP : CLS_BPDU;
        frame(cls, 1'b0, 1'b0, ACT_DEFAULT, {b == 12 - j, b == 9 - j, b == 6 - j}, TAG_SYS_DEFAULT);
      end
    end
    for (int t = 0; t < 4; t++) begin
      wr(ADR_RSV, 32'((t << 2) | (3 - t)));
      frame(CLS_GXRP, 1'b0, 1'b0, ACT_DEFAULT, 3'h0, tx_tag_t'(t));
      frame(CLS_SLOWGRP, 1'b0, 1'b0, ACT_DEFAULT, 3'h0, tx_tag_t'(3 - t));
      frame(CLS_BPDU, 1'b0, 1'b0, ACT_DEFAULT, 3'h0, TAG_SYS_DEFAULT);
    end
    // ****************************************************************
    // snooping and router port aging
    // ****************************************************************
    wr(ADR_IGM, 32'h0000_03A1);
    rdchk("igmpRw", ADR_IGM, 32'h0000_03A1);
    query(3'h2);
    portsChk("snoopOff", 6'h00);
    wr(ADR_EN, 32'h0000_0001);
    query(3'h2);
    portsChk("learned", 6'h04);
    rdchk("status", ADR_ST, 32'h0000_0404);
    wr(ADR_EN, 32'h0000_0003);
    portsChk("static", 6'h25);
    wr(ADR_EN, 32'h0000_0001);
    portsChk("staticOff", 6'h04);
    for (int rob = 0; rob < 4; rob++) begin
      wr(ADR_IGM, 32'((QINT << 8) | (rob << 6) | 'h21));
      age(QINT * (rob == 0 ? 1 : rob));
    end
    query(3'h2);
    repeat (QINT * 3 * TICK / 2) @(negedge ref_clk);
    query(3'h2);
    repeat ((QINT * 3 - 1) * TICK - 4) @(negedge ref_clk);
    check("reload", 32'(routerPorts[2]), 32'h0000_0001);
    wr(ADR_EN, 32'h0000_0000);
    portsChk("disable", 6'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("rsvReset2", ADR_RSV, 32'h0000_0000);
    rdchk("igmpReset2", ADR_IGM, 32'h0000_7C80);
    finish_test();
  end
endmodule // test_reserved_mcast_igmp_ctrl
